// ===== rtl/bram_pkg.sv
// constants, layouts and address helpers for the 4 kbit block ram
// assumes a 32-bit apb register bus and a single pclk domain
package bram_pkg;

  // ==========================================================
  // array geometry
  localparam int unsigned ARRAY_BITS = 4096;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ROWS = ARRAY_BITS / WORD_W;
  localparam int unsigned ROW_AW = 8;
  localparam int unsigned PORT_AW = 11;
  localparam int unsigned PADDR_W = 8;

  typedef enum logic [1:0] {
    ARR_256X16,
    ARR_512X8,
    ARR_1024X4,
    ARR_2048X2
  } arrangement_t;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRELOAD_ADDR = 8'h04;
  localparam logic [7:0] OFS_PRELOAD_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_WR_COUNT = 8'h10;
  localparam logic [7:0] OFS_RD_COUNT = 8'h14;

  // ==========================================================
  // control fields and reset value
  localparam int unsigned CTRL_ARR_LSB = 0;
  localparam int unsigned CTRL_RD_FALL = 2;
  localparam int unsigned CTRL_WR_FALL = 3;
  localparam int unsigned CTRL_WR_LOCK = 4;
  localparam int unsigned CTRL_PRELOAD = 5;
  localparam int unsigned CTRL_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h20;

  // ==========================================================
  // status fields
  localparam int unsigned ST_PRELOAD_REJ = 0;
  localparam int unsigned ST_WR_BLOCKED = 1;
  localparam int unsigned ST_PRELOAD_MODE = 2;
  localparam int unsigned ST_ARR_LSB = 4;

  // ==========================================================
  // address decoding shared by write and read side
  function automatic logic [7:0] row_of(arrangement_t arr, logic [10:0] a);
    logic [10:0] s;
    s = a >> arr;
    return s[7:0];
  endfunction

  function automatic logic [3:0] shift_of(arrangement_t arr, logic [10:0] a);
    logic [3:0] lane;
    logic [7:0] bitpos;
    lane = a[3:0] & ((4'h1 << arr) - 4'h1);
    // widen first, lane times sixteen overflows four bits
    bitpos = {lane, 4'h0} >> arr;
    return bitpos[3:0];
  endfunction

  function automatic logic [15:0] width_mask(arrangement_t arr);
    case (arr)
      ARR_256X16: return 16'hffff;
      ARR_512X8: return 16'h00ff;
      ARR_1024X4: return 16'h000f;
      default: return 16'h0003;
    endcase
  endfunction

endpackage

// ===== rtl/clk_edge_sense.sv
// port clock sampler: two-flop synchroniser and polarity-selected edge pulse
// assumes the port clock runs well below half of pclk
`timescale 1ns/1ps
`default_nettype none
module clk_edge_sense (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_pin,
  input wire logic falling,
  output logic edge_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // ==========================================================
  // synchroniser, meta_ff read only by sync_ff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= clk_pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign edge_pulse = falling ? (last_ff & ~sync_ff) : (sync_ff & ~last_ff);
endmodule
`default_nettype wire

// ===== rtl/ram_array.sv
// 256 x 16 storage with per-bit write enables and asynchronous row read
// assumes the caller registers every address and user data word in front of it
`timescale 1ns/1ps
`default_nettype none
module ram_array (
  input wire logic pclk,
  input wire logic we,
  input wire logic [7:0] wrow,
  input wire logic [15:0] wdata,
  input wire logic [15:0] bit_en,
  input wire logic [7:0] rrow,
  output logic [15:0] rword
);
  // no reset: contents survive user reset, unwritten rows stay unknown
  logic [15:0] mem [256];
  logic [15:0] merged;

  // ==========================================================
  // bitwise write, one process owns the array
  for (genvar i = 0; i < 16; i++) begin : g_bit
    assign merged[i] = bit_en[i] ? wdata[i] : mem[wrow][i];
  end

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[wrow] <= merged;
    end
  end

  assign rword = mem[rrow];
endmodule
`default_nettype wire

// ===== rtl/block_ram_4kbit.sv
// 4 kbit block ram with apb control, preload and two sampled port clocks
// assumes port data/enables come from pclk logic, clocks arrive as pins
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one array of exactly 4096 bits shared by every arrangement
// - separate write and read ports; one port pair serves single or dual use
// - 256x16 uses 8-bit addresses, 16-bit data and a 16-bit write mask
// - 512x8 uses 9-bit addresses and 8-bit data, mask ignored
// - 1024x4 uses 10-bit addresses and 4-bit data, mask ignored
// - 2048x2 uses 11-bit addresses and 2-bit data, mask ignored
// - read and write clock each select rising or falling active edge
// - contents can be preloaded before user operation starts
// - preloaded array with writes locked behaves as a rom
// - preload never sets row zero; it stays undefined until written
// - addresses and data are registered on the port's active edge
module block_ram_4kbit
  import bram_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bram_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_clk_pin,
  input wire logic wr_en,
  input wire logic wr_clk_en,
  input wire logic [bram_pkg::PORT_AW-1:0] write_address_port,
  input wire logic [bram_pkg::WORD_W-1:0] wr_data,
  input wire logic [bram_pkg::WORD_W-1:0] wr_mask,
  input wire logic rd_clk_pin,
  input wire logic rd_en,
  input wire logic rd_clk_en,
  input wire logic [bram_pkg::PORT_AW-1:0] read_address_port,
  output logic [bram_pkg::WORD_W-1:0] rd_data
);
  import bram_pkg::*;

  // ==========================================================
  // declarations
  logic [CTRL_W-1:0] ctrl_ff;
  logic [ROW_AW-1:0] preload_addr_ff;
  logic preload_rej_ff;
  logic wr_blocked_ff;
  logic [15:0] wr_count_ff;
  logic [15:0] rd_count_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [15:0] rd_data_ff;

  logic setup_phase;
  logic access_done;
  logic wr_access;
  logic mapped;

  arrangement_t arr;
  logic rd_fall;
  logic wr_fall;
  logic wr_lock;
  logic preload_mode;

  logic wr_edge;
  logic rd_edge;

  logic wgo_ff;
  logic [PORT_AW-1:0] write_address_port_ff;
  logic [WORD_W-1:0] wdata_ff;
  logic [WORD_W-1:0] wmask_ff;
  logic rgo_ff;
  logic [PORT_AW-1:0] read_address_port_ff;

  logic user_write_try;
  logic user_write_ok;
  logic user_read_ok;
  logic preload_hit;
  logic preload_write;
  logic preload_reject;

  logic arr_we;
  logic [ROW_AW-1:0] arr_wrow;
  logic [WORD_W-1:0] arr_wdata;
  logic [WORD_W-1:0] arr_bit_en;
  logic [WORD_W-1:0] arr_rword;
  logic [WORD_W-1:0] user_bits;
  logic [WORD_W-1:0] user_mask;

  // ==========================================================
  // control field views
  assign arr = arrangement_t'(ctrl_ff[CTRL_ARR_LSB +: 2]);
  assign rd_fall = ctrl_ff[CTRL_RD_FALL];
  assign wr_fall = ctrl_ff[CTRL_WR_FALL];
  assign wr_lock = ctrl_ff[CTRL_WR_LOCK];
  assign preload_mode = ctrl_ff[CTRL_PRELOAD];

  // ==========================================================
  // apb handshake
  // zero wait states: pready rises in the first access cycle
  // unmapped offsets read zero and answer with pslverr
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign wr_access = access_done & pwrite;

  always_comb begin
    mapped = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: begin
        nxt_prdata[CTRL_W-1:0] = ctrl_ff;
      end
      OFS_PRELOAD_ADDR: begin
        nxt_prdata[ROW_AW-1:0] = preload_addr_ff;
      end
      OFS_PRELOAD_DATA: begin
        nxt_prdata = 32'h0000_0000;
      end
      OFS_STATUS: begin
        nxt_prdata[ST_PRELOAD_REJ] = preload_rej_ff;
        nxt_prdata[ST_WR_BLOCKED] = wr_blocked_ff;
        nxt_prdata[ST_PRELOAD_MODE] = preload_mode;
        nxt_prdata[ST_ARR_LSB +: 2] = ctrl_ff[CTRL_ARR_LSB +: 2];
      end
      OFS_WR_COUNT: begin
        nxt_prdata[15:0] = wr_count_ff;
      end
      OFS_RD_COUNT: begin
        nxt_prdata[15:0] = rd_count_ff;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    nxt_pslverr = ~mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup_phase;
      if (setup_phase) begin
        pslverr_ff <= nxt_pslverr;
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      end else if (access_done) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control register
  // arrangement change with data in the array reinterprets the bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_access && paddr == OFS_CTRL) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // preload path, active only while preload mode is set
  assign preload_hit = wr_access & (paddr == OFS_PRELOAD_DATA);
  assign preload_write = preload_hit & preload_mode & (preload_addr_ff != 8'h00);
  assign preload_reject = preload_hit & ~preload_write;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preload_addr_ff <= 8'h01;
    end else if (wr_access && paddr == OFS_PRELOAD_ADDR) begin
      preload_addr_ff <= pwdata[ROW_AW-1:0];
    end else if (preload_write) begin
      // auto increment lets software stream rows 1 to 255 in one run
      preload_addr_ff <= preload_addr_ff + 8'h01;
    end
  end

  // ==========================================================
  // port clock edge detection
  // three flops per pin, so an event lags its pin edge by two pclk
  clk_edge_sense u_wr_edge (
    .pclk(pclk),
    .presetn(presetn),
    .clk_pin(wr_clk_pin),
    .falling(wr_fall),
    .edge_pulse(wr_edge)
  );

  clk_edge_sense u_rd_edge (
    .pclk(pclk),
    .presetn(presetn),
    .clk_pin(rd_clk_pin),
    .falling(rd_fall),
    .edge_pulse(rd_edge)
  );

  // ==========================================================
  // input registers at the array, loaded on the active edge
  // address and data load on every active edge; enables gate only go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wgo_ff <= 1'b0;
      write_address_port_ff <= 11'h000;
      wdata_ff <= 16'h0000;
      wmask_ff <= 16'h0000;
    end else begin
      wgo_ff <= wr_edge & wr_en & wr_clk_en;
      if (wr_edge) begin
        write_address_port_ff <= write_address_port;
        wdata_ff <= wr_data;
        wmask_ff <= wr_mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgo_ff <= 1'b0;
      read_address_port_ff <= 11'h000;
    end else begin
      rgo_ff <= rd_edge & rd_en & rd_clk_en;
      if (rd_edge) begin
        read_address_port_ff <= read_address_port;
      end
    end
  end

  // ==========================================================
  // user write qualification
  // locked or preloading array ignores the user write port
  assign user_write_try = wgo_ff;
  assign user_write_ok = wgo_ff & ~wr_lock & ~preload_mode;
  assign user_read_ok = rgo_ff & ~preload_mode;

  // narrow arrangements place the low data bits in their lane
  assign user_bits = 16'(wdata_ff << shift_of(arr, write_address_port_ff));
  assign user_mask = 16'(width_mask(arr) << shift_of(arr, write_address_port_ff));

  always_comb begin
    arr_we = 1'b0;
    arr_wrow = 8'h00;
    arr_wdata = 16'h0000;
    arr_bit_en = 16'h0000;
    if (preload_write) begin
      arr_we = 1'b1;
      arr_wrow = preload_addr_ff;
      arr_wdata = pwdata[WORD_W-1:0];
      arr_bit_en = 16'hffff;
    end else if (user_write_ok) begin
      arr_we = 1'b1;
      arr_wrow = row_of(arr, write_address_port_ff);
      arr_wdata = user_bits;
      if (arr == ARR_256X16) begin
        arr_bit_en = ~wmask_ff;
      end else begin
        arr_bit_en = user_mask;
      end
    end
  end

  // ==========================================================
  // storage
  // row read is combinational, the registered copy is rd_data_ff
  ram_array u_array (
    .pclk(pclk),
    .we(arr_we),
    .wrow(arr_wrow),
    .wdata(arr_wdata),
    .bit_en(arr_bit_en),
    .rrow(row_of(arr, read_address_port_ff)),
    .rword(arr_rword)
  );

  // ==========================================================
  // read data register, holds between reads
  // bits above the arrangement width read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_ff <= 16'h0000;
    end else if (user_read_ok) begin
      rd_data_ff <= (arr_rword >> shift_of(arr, read_address_port_ff)) & width_mask(arr);
    end
  end

  // ==========================================================
  // sticky status, set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preload_rej_ff <= 1'b0;
      wr_blocked_ff <= 1'b0;
    end else begin
      if (preload_reject) begin
        preload_rej_ff <= 1'b1;
      end else if (wr_access && paddr == OFS_STATUS && pwdata[ST_PRELOAD_REJ]) begin
        preload_rej_ff <= 1'b0;
      end
      if (user_write_try && !user_write_ok) begin
        wr_blocked_ff <= 1'b1;
      end else if (wr_access && paddr == OFS_STATUS && pwdata[ST_WR_BLOCKED]) begin
        wr_blocked_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // activity counters, wrap at 16 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_count_ff <= 16'h0000;
    end else if (user_write_ok) begin
      wr_count_ff <= wr_count_ff + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_count_ff <= 16'h0000;
    end else if (user_read_ok) begin
      rd_count_ff <= rd_count_ff + 16'h0001;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign rd_data = rd_data_ff;
endmodule
`default_nettype wire

// ===== tb/block_ram_4kbit_sva.sv
// port assertions for the 4 kbit block ram
// assumes one pclk domain; bound to every block_ram_4kbit
`timescale 1ns/1ps
`default_nettype none
module block_ram_4kbit_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bram_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rd_clk_pin,
  input wire logic rd_en,
  input wire logic rd_clk_en,
  input wire logic [bram_pkg::WORD_W-1:0] rd_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======
  // register bus
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_acc; pready |-> psel && penable; endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready too long");
  property p_unmapped; pready && paddr > 8'h14 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  property p_mapped;
    pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  // ======
  // read port
  property p_wake; $rose(presetn) |-> !pready && rd_data == 16'h0; endproperty
  a_wake: assert property (p_wake) else $error("outputs not quiet");
  // output moves only two edges after a qualified capture
  property p_rd_cause; !$stable(rd_data) |-> $past(rd_en, 2) && $past(rd_clk_en, 2); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read without enables");
  property p_rd_pin; !$stable(rd_data) |-> $past(rd_clk_pin, 4) != $past(rd_clk_pin, 5); endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("read off pin edge");
  c_err: cover property (pready && pslverr);
  c_wr: cover property (pready && pwrite);
  c_rd: cover property (!$stable(rd_data));
endmodule
bind block_ram_4kbit block_ram_4kbit_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rd_clk_pin(rd_clk_pin), .rd_en(rd_en),
  .rd_clk_en(rd_clk_en), .rd_data(rd_data));
`default_nettype wire

// ===== tb/fabric_port_model.sv
// fabric user logic driving the write and read ports
// assumes pclk is the bench clock; port clocks move only inside ops and set_pol
`timescale 1ns/1ps
`default_nettype none
module fabric_port_model (
  input wire logic pclk,
  output logic wr_clk_pin,
  output logic wr_en,
  output logic wr_clk_en,
  output logic [bram_pkg::PORT_AW-1:0] write_address_port,
  output logic [bram_pkg::WORD_W-1:0] wr_data,
  output logic [bram_pkg::WORD_W-1:0] wr_mask,
  output logic rd_clk_pin,
  output logic rd_en,
  output logic rd_clk_en,
  output logic [bram_pkg::PORT_AW-1:0] read_address_port
);
  logic wf = 1'b0;
  logic rf = 1'b0;
  initial begin
    {wr_clk_pin, wr_en, wr_clk_en, rd_clk_pin, rd_en, rd_clk_en} = 6'h0;
    write_address_port = 11'h0;
    read_address_port = 11'h0;
    wr_data = 16'h0;
    wr_mask = 16'h0;
  end
  // ======
  // idle level follows the chosen polarity
  task automatic set_pol(input logic w, input logic r);
    @(posedge pclk);
    wf <= w;
    rf <= r;
    wr_clk_pin <= w;
    rd_clk_pin <= r;
    repeat (4) @(posedge pclk);
  endtask
  // enables stay up across the inactive edge, inputs inverted: a wrong-edge capture shows
  task automatic wr_op(input logic [10:0] a, input logic [15:0] d, m, input logic e, c);
    @(posedge pclk);
    write_address_port <= a;
    wr_data <= d;
    wr_mask <= m;
    wr_en <= e;
    wr_clk_en <= c;
    wr_clk_pin <= !wf;
    repeat (5) @(posedge pclk);
    wr_clk_pin <= wf;
    write_address_port <= ~a;
    wr_data <= ~d;
    repeat (5) @(posedge pclk);
    wr_en <= 1'b0;
    wr_clk_en <= 1'b0;
  endtask
  task automatic rd_op(input logic [10:0] a, input logic e, c);
    @(posedge pclk);
    read_address_port <= a;
    rd_en <= e;
    rd_clk_en <= c;
    rd_clk_pin <= !rf;
    repeat (5) @(posedge pclk);
    rd_clk_pin <= rf;
    read_address_port <= ~a;
    repeat (5) @(posedge pclk);
    rd_en <= 1'b0;
    rd_clk_en <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/block_ram_4kbit_tb.sv
// self-checking bench for the 4 kbit block ram
// assumes bram_pkg, the design and the port model are compiled first
`timescale 1ns/1ps
`default_nettype none
module block_ram_4kbit_tb;
  import bram_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wck, wen, wcen, rck, ren, rcen;
  logic [PORT_AW-1:0] wa, ra;
  logic [WORD_W-1:0] wd, wm, rd_data;
  logic [31:0] d;
  logic e;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  block_ram_4kbit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_clk_pin(wck), .wr_en(wen), .wr_clk_en(wcen),
    .write_address_port(wa), .wr_data(wd), .wr_mask(wm), .rd_clk_pin(rck), .rd_en(ren),
    .rd_clk_en(rcen), .read_address_port(ra), .rd_data(rd_data));
  fabric_port_model u_fab (.pclk(pclk), .wr_clk_pin(wck), .wr_en(wen), .wr_clk_en(wcen),
    .write_address_port(wa), .wr_data(wd), .wr_mask(wm), .rd_clk_pin(rck), .rd_en(ren),
    .rd_clk_en(rcen), .read_address_port(ra));
  initial begin
    forever #50 pclk = ~pclk;
  end
  // ======
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(d, x);
  endtask
  task automatic rdchk(input logic [10:0] a, input logic [31:0] x);
    u_fab.rd_op(a, 1'b1, 1'b1);
    chk({16'h0, rd_data}, x);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      test_done();
    end
  end
  // ======
  // tests
  initial begin
    int w;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_CTRL, 32'h20);
    rchk(OFS_PRELOAD_ADDR, 32'h1);
    rchk(OFS_STATUS, 32'h4);
    $display("reset test done");
    for (int i = 1; i < 4; i++) apb(1'b1, OFS_PRELOAD_DATA, i * 32'h1111);
    apb(1'b1, OFS_PRELOAD_ADDR, 32'h0);
    apb(1'b1, OFS_PRELOAD_DATA, 32'hbeef);
    rchk(OFS_STATUS, 32'h5);
    apb(1'b1, OFS_CTRL, 32'h10);
    for (int i = 1; i < 4; i++) rdchk(11'(i), i * 32'h1111);
    u_fab.wr_op(11'h1, 16'h5555, 16'h0, 1'b1, 1'b1);
    rdchk(11'h1, 32'h1111);
    rchk(OFS_STATUS, 32'h3);
    $display("preload test done");
    apb(1'b1, OFS_CTRL, 32'h0);
    u_fab.wr_op(11'h0, 16'hffff, 16'h0, 1'b1, 1'b1);
    u_fab.wr_op(11'h0, 16'h0, 16'hff00, 1'b1, 1'b1);
    rdchk(11'h0, 32'hff00);
    u_fab.wr_op(11'h0, 16'h0, 16'h0, 1'b0, 1'b1);
    u_fab.wr_op(11'h0, 16'h0, 16'h0, 1'b1, 1'b0);
    rdchk(11'h0, 32'hff00);
    u_fab.rd_op(11'h1, 1'b0, 1'b1);
    u_fab.rd_op(11'h1, 1'b1, 1'b0);
    chk({16'h0, rd_data}, 32'hff00);
    $display("enable test done");
    u_fab.wr_op(11'h5, 16'h1234, 16'h0, 1'b1, 1'b1);
    for (int a = 1; a < 4; a++) begin
      w = 16 >> a;
      apb(1'b1, OFS_CTRL, 32'(a));
      for (int l = 0; l < (1 << a); l++) begin
        rdchk(11'((5 << a) | l), (32'h1234 >> (l * w)) & ((32'h1 << w) - 1));
      end
      u_fab.wr_op(11'((6 << a) | 1), 16'hffff, 16'hffff, 1'b1, 1'b1);
      rdchk(11'((6 << a) | 1), (32'h1 << w) - 1);
    end
    $display("arrangement test done");
    for (int p = 1; p < 4; p++) begin
      apb(1'b1, OFS_CTRL, 32'(p << 2));
      u_fab.set_pol(p[1], p[0]);
      u_fab.wr_op(11'h7, 16'(p * 16'h0101), 16'h0, 1'b1, 1'b1);
      rdchk(11'h7, p * 32'h0101);
    end
    $display("polarity test done");
    u_fab.wr_op(11'h8, 16'hcafe, 16'h0, 1'b1, 1'b1);
    u_fab.wr_op(11'h9, 16'hf00d, 16'h0, 1'b1, 1'b1);
    u_fab.rd_op(11'h8, 1'b1, 1'b1);
    d[15:0] = rd_data;
    u_fab.rd_op(11'h9, 1'b1, 1'b1);
    chk({rd_data, d[15:0]}, 32'hf00dcafe);
    rchk(OFS_WR_COUNT, 32'hb);
    rchk(OFS_RD_COUNT, 32'h1c);
    apb(1'b1, OFS_STATUS, 32'h3);
    rchk(OFS_STATUS, 32'h0);
    $display("cascade and count test done");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    $display("unmapped test done");
    test_done();
  end
endmodule
`default_nettype wire
